// File: rtl/eilc_pkg.sv
// Package for the enclave instruction legality check block
package eilc_pkg;

	// Instruction class codes presented at the decode port
	typedef enum logic [5:0] {
		EILC_OP_NONE,
		EILC_OP_ID_QUERY,
		EILC_OP_SAFER_MODE,
		EILC_OP_PERF_READ,
		EILC_OP_GLOBAL_TABLE_STORE,
		EILC_OP_INTERRUPT_TABLE_STORE,
		EILC_OP_LOCAL_TABLE_STORE,
		EILC_OP_TASK_REG_STORE,
		EILC_OP_HYPERCALL,
		EILC_OP_VM_FUNCTION,
		EILC_OP_PORT_IN,
		EILC_OP_STRING_PORT_IN,
		EILC_OP_PORT_OUT,
		EILC_OP_STRING_PORT_OUT,
		EILC_OP_FAR_CALL,
		EILC_OP_FAR_JUMP,
		EILC_OP_FAR_RET,
		EILC_OP_SOFT_INT,
		EILC_OP_INT_RETURN,
		EILC_OP_FAR_PTR_LOAD,
		EILC_OP_SEG_MOV,
		EILC_OP_SEG_POP,
		EILC_OP_FAST_SYS_CALL,
		EILC_OP_FAST_SYS_ENTRY,
		EILC_OP_MSW_STORE,
		EILC_OP_ENTRY_LEAF,
		EILC_OP_RESUME_LEAF,
		EILC_OP_TIMESTAMP,
		EILC_OP_TIMESTAMP_ID,
		EILC_OP_RANDOM,
		EILC_OP_RANDOM_SEED,
		EILC_OP_SPIN_WAIT,
		EILC_OP_SINGLE_STEP,
		EILC_OP_BREAKPOINT,
		EILC_OP_PERM_EXTEND,
		EILC_OP_PAGE_INFO_READ,
		EILC_OP_VCHILD_MARK,
		EILC_OP_CONTEXT_SET,
		EILC_OP_ACCESS,
		EILC_OP_OTHER
	} eilc_op_e;

	// Verdict for one instruction
	typedef enum logic [2:0] {
		EILC_RES_LEGAL,
		EILC_RES_INVALID_OPCODE,
		EILC_RES_GEN_PROT,
		EILC_RES_VM_EXIT,
		EILC_RES_PAGE_FAULT
	} eilc_res_e;

	// Exit reason codes (chosen)
	localparam logic [15:0] EILC_EXIT_TIMESTAMP   = 16'h0010;
	localparam logic [15:0] EILC_EXIT_RANDOM      = 16'h0039;
	localparam logic [15:0] EILC_EXIT_SPIN_WAIT   = 16'h0028;
	localparam logic [15:0] EILC_EXIT_RANDOM_SEED = 16'h003d;

	// Exit reason word layout
	localparam int          EILC_EXIT_WIDTH       = 32;
	localparam int          EILC_EXIT_ENCLAVE_BIT = 27;

	// Identification leaf answer
	localparam logic [31:0] EILC_ID_LEAF          = 32'h0000_0012;
	localparam logic [31:0] EILC_ID_SUBLEAF       = 32'h0000_0000;
	localparam int          EILC_ID_OVERSUB_BIT_A = 5;
	localparam int          EILC_ID_OVERSUB_BIT_B = 6;
	localparam int          EILC_ID_GEN1_BIT      = 0;
	localparam int          EILC_ID_GEN2_BIT      = 1;

	// Page map geometry
	localparam int          EILC_PAGES            = 16;
	localparam int          EILC_PAGE_IDX_W       = 4;
	localparam int          EILC_PERM_W           = 3;
	localparam int          EILC_TYPE_W           = 8;
	localparam int          EILC_CTX_W            = 64;
	localparam logic [7:0]  EILC_TYPE_CONTROL     = 8'h00;

	// One enclave page map entry
	typedef struct packed {
		logic                      valid;
		logic [EILC_PERM_W-1:0]    perm;
		logic [EILC_TYPE_W-1:0]    page_type;
		logic [EILC_PAGE_IDX_W-1:0] owner;
	} eilc_map_entry_s;

	// Decode request
	typedef struct packed {
		logic                       valid;
		eilc_op_e                   op;
		logic [EILC_PAGE_IDX_W-1:0] page;
		logic [EILC_PERM_W-1:0]     perm;
		logic [EILC_CTX_W-1:0]      ctx;
		logic [31:0]                leaf;
		logic [31:0]                subleaf;
	} eilc_req_s;

	// Monitor execution controls
	typedef struct packed {
		logic timestamp_exit;
		logic random_exit;
		logic spin_wait_exit;
		logic spin_loop_exit;
		logic timestamp_disable;
		logic [1:0] current_privilege_level;
	} eilc_ctrl_s;

	// Verdict output
	typedef struct packed {
		logic                       valid;
		eilc_res_e                  result;
		logic [EILC_EXIT_WIDTH-1:0] exit_reason;
		logic                       commit;
		logic [31:0]                id_data;
		logic [EILC_TYPE_W-1:0]     page_type;
		logic [EILC_PAGE_IDX_W-1:0] owner;
	} eilc_resp_s;

endpackage

// File: rtl/eilc_page_map.sv
// Enclave page map with permission extension and control-structure data
`timescale 1ns/1ps
module eilc_page_map
	import eilc_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_load,
	input  wire logic [EILC_PAGE_IDX_W-1:0] i_load_page,
	input  wire eilc_map_entry_s            i_load_entry,
	input  wire logic                       i_extend,
	input  wire logic                       i_vchild,
	input  wire logic                       i_ctx_set,
	input  wire logic [EILC_PAGE_IDX_W-1:0] i_page,
	input  wire logic [EILC_PERM_W-1:0]     i_perm,
	input  wire logic [EILC_CTX_W-1:0]      i_ctx,
	output eilc_map_entry_s                 o_entry,
	output logic                            o_vchild,
	output logic [EILC_CTX_W-1:0]           o_ctx
);

	typedef struct packed {
		eilc_map_entry_s [EILC_PAGES-1:0] map;
		logic [EILC_PAGES-1:0]            vchild;
		logic [EILC_PAGES-1:0][EILC_CTX_W-1:0] ctx;
	} eilc_pm_state_s;

	eilc_pm_state_s state;
	eilc_pm_state_s next_state;

	// Map updates
	always_comb
	begin
		next_state = state;
		if (i_load)
			next_state.map[i_load_page] = i_load_entry;
		if (i_extend && state.map[i_page].valid)
			next_state.map[i_page].perm = state.map[i_page].perm | i_perm;
		if (i_vchild)
			next_state.vchild[i_page] = 1'b1;
		if (i_ctx_set)
			next_state.ctx[i_page] = i_ctx;
		if (i_load && i_load_entry.page_type == EILC_TYPE_CONTROL)
			next_state.vchild[i_load_page] = 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state <= '0;
		else
			state <= next_state;
	end

	// Combinational lookup: entry of the page in question, marker and context of its owner page
	assign o_entry  = state.map[i_page];
	assign o_vchild = state.vchild[state.map[i_page].owner];
	assign o_ctx    = state.ctx[state.map[i_page].owner];

endmodule

// File: rtl/eilc_tlb.sv
// Cached translation permissions per enclave page
`timescale 1ns/1ps
module eilc_tlb
	import eilc_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_fill,
	input  wire logic                       i_drop,
	input  wire logic                       i_flush,
	input  wire logic [EILC_PAGE_IDX_W-1:0] i_page,
	input  wire logic [EILC_PERM_W-1:0]     i_perm,
	output logic                            o_hit,
	output logic [EILC_PERM_W-1:0]          o_perm
);

	typedef struct packed {
		logic [EILC_PAGES-1:0]                  valid;
		logic [EILC_PAGES-1:0][EILC_PERM_W-1:0] perm;
	} eilc_tlb_state_s;

	eilc_tlb_state_s state;
	eilc_tlb_state_s next_state;

	// Fill on a good access, drop on a faulting access, clear all on a flush
	always_comb
	begin
		next_state = state;
		if (i_flush)
			next_state.valid = '0;
		if (i_drop)
			next_state.valid[i_page] = 1'b0;
		if (i_fill)
		begin
			next_state.valid[i_page] = 1'b1;
			next_state.perm[i_page]  = i_perm;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign o_hit  = state.valid[i_page];
	assign o_perm = state.perm[i_page];

endmodule

// File: rtl/eilc_top.sv
// Enclave instruction legality check and page management top
`timescale 1ns/1ps
module eilc_top
	import eilc_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire eilc_req_s                  i_req,
	input  wire eilc_ctrl_s                 i_ctrl,
	input  wire logic                       i_in_enclave,
	input  wire logic                       i_gen2,
	input  wire logic                       i_map_load,
	input  wire logic [EILC_PAGE_IDX_W-1:0] i_map_page,
	input  wire eilc_map_entry_s            i_map_entry,
	input  wire logic                       i_tlb_flush,
	output eilc_resp_s                      o_resp,
	output logic [EILC_CTX_W-1:0]           o_info_ctx,
	output logic                            o_vchild_locked
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		eilc_resp_s             resp;
		logic [EILC_CTX_W-1:0]  info_ctx;
		logic                   vchild_locked;
	} eilc_top_state_s;

	eilc_top_state_s state;
	eilc_top_state_s next_state;

	eilc_map_entry_s        map_entry;
	logic                   map_vchild;
	logic [EILC_CTX_W-1:0]  map_ctx;
	logic                   tlb_hit;
	logic [EILC_PERM_W-1:0] tlb_perm;

	eilc_res_e              verdict;
	logic [15:0]            exit_code;
	logic                   commit;
	logic                   do_extend;
	logic                   do_vchild;
	logic                   do_ctx_set;
	logic                   do_fill;
	logic                   do_drop;

	////////////////////////////////////////////////////////////////////////////////
	// Submodules

	eilc_page_map u_map (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_load       (i_map_load),
		.i_load_page  (i_map_page),
		.i_load_entry (i_map_entry),
		.i_extend     (do_extend),
		.i_vchild     (do_vchild),
		.i_ctx_set    (do_ctx_set),
		.i_page       (i_req.page),
		.i_perm       (i_req.perm),
		.i_ctx        (i_req.ctx),
		.o_entry      (map_entry),
		.o_vchild     (map_vchild),
		.o_ctx        (map_ctx)
	);

	eilc_tlb u_tlb (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_fill  (do_fill),
		.i_drop  (do_drop),
		.i_flush (i_tlb_flush),
		.i_page  (i_req.page),
		.i_perm  (map_entry.perm),
		.o_hit   (tlb_hit),
		.o_perm  (tlb_perm)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Classification

	// Verdict for the presented instruction
	always_comb
	begin
		verdict   = EILC_RES_LEGAL;
		exit_code = 16'h0000;
		if (i_in_enclave)
		begin
			unique case (i_req.op)
				EILC_OP_ID_QUERY, EILC_OP_SAFER_MODE, EILC_OP_PERF_READ,
				EILC_OP_GLOBAL_TABLE_STORE, EILC_OP_INTERRUPT_TABLE_STORE,
				EILC_OP_LOCAL_TABLE_STORE, EILC_OP_TASK_REG_STORE,
				EILC_OP_HYPERCALL, EILC_OP_VM_FUNCTION:
					verdict = EILC_RES_INVALID_OPCODE;
				EILC_OP_PORT_IN, EILC_OP_STRING_PORT_IN, EILC_OP_PORT_OUT,
				EILC_OP_STRING_PORT_OUT:
					verdict = EILC_RES_INVALID_OPCODE;
				EILC_OP_FAR_CALL, EILC_OP_FAR_JUMP, EILC_OP_FAR_RET,
				EILC_OP_SOFT_INT, EILC_OP_INT_RETURN, EILC_OP_FAR_PTR_LOAD,
				EILC_OP_SEG_MOV, EILC_OP_SEG_POP, EILC_OP_FAST_SYS_CALL,
				EILC_OP_FAST_SYS_ENTRY:
					verdict = EILC_RES_INVALID_OPCODE;
				EILC_OP_MSW_STORE:
					verdict = EILC_RES_INVALID_OPCODE;
				EILC_OP_ENTRY_LEAF, EILC_OP_RESUME_LEAF:
					verdict = EILC_RES_GEN_PROT;
				EILC_OP_TIMESTAMP, EILC_OP_TIMESTAMP_ID:
				begin
					if (!i_gen2)
						verdict = EILC_RES_INVALID_OPCODE;
					else if (i_ctrl.timestamp_disable && i_ctrl.current_privilege_level != 2'h0)
						verdict = EILC_RES_GEN_PROT;
					else if (i_ctrl.timestamp_exit)
					begin
						verdict   = EILC_RES_VM_EXIT;
						exit_code = EILC_EXIT_TIMESTAMP;
					end
				end
				EILC_OP_RANDOM, EILC_OP_RANDOM_SEED:
				begin
					if (i_ctrl.random_exit)
					begin
						verdict   = EILC_RES_VM_EXIT;
						exit_code = (i_req.op == EILC_OP_RANDOM) ? EILC_EXIT_RANDOM
							: EILC_EXIT_RANDOM_SEED;
					end
				end
				EILC_OP_SPIN_WAIT:
				begin
					// Loop exiting is ignored: enclave code is never at level 0
					if (i_ctrl.spin_wait_exit)
					begin
						verdict   = EILC_RES_VM_EXIT;
						exit_code = EILC_EXIT_SPIN_WAIT;
					end
				end
				EILC_OP_SINGLE_STEP, EILC_OP_BREAKPOINT:
					verdict = EILC_RES_LEGAL;
				EILC_OP_ACCESS:
				begin
					// Stale cached permissions fault, and the faulting access drops them
					if (tlb_hit && ((i_req.perm & ~tlb_perm) != '0))
						verdict = EILC_RES_PAGE_FAULT;
					else if ((i_req.perm & ~map_entry.perm) != '0 || !map_entry.valid)
						verdict = EILC_RES_PAGE_FAULT;
					else
						verdict = EILC_RES_LEGAL;
				end
				default:
					verdict = EILC_RES_LEGAL;
			endcase
		end
		else if (i_req.op == EILC_OP_SPIN_WAIT)
		begin
			if (i_ctrl.spin_wait_exit || (i_ctrl.spin_loop_exit && i_ctrl.current_privilege_level == 2'h0))
			begin
				verdict   = EILC_RES_VM_EXIT;
				exit_code = EILC_EXIT_SPIN_WAIT;
			end
		end
	end

	// Only a legal instruction touches map state; a faulting access drops its TLB entry
	always_comb
	begin
		commit     = i_req.valid && verdict == EILC_RES_LEGAL;
		do_extend  = commit && i_req.op == EILC_OP_PERM_EXTEND && i_in_enclave;
		do_vchild  = commit && i_req.op == EILC_OP_VCHILD_MARK;
		do_ctx_set = commit && i_req.op == EILC_OP_CONTEXT_SET;
		do_fill    = commit && i_req.op == EILC_OP_ACCESS && i_in_enclave;
		do_drop    = i_req.valid && i_req.op == EILC_OP_ACCESS
			&& verdict == EILC_RES_PAGE_FAULT;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Response register

	always_comb
	begin
		next_state = state;
		next_state.resp.valid = i_req.valid;
		if (i_req.valid)
		begin
			next_state.resp.result      = verdict;
			next_state.resp.commit      = commit;
			next_state.resp.exit_reason = '0;
			next_state.resp.id_data     = '0;
			next_state.resp.page_type   = '0;
			next_state.resp.owner       = '0;
			if (verdict == EILC_RES_VM_EXIT)
			begin
				next_state.resp.exit_reason[15:0] = exit_code;
				next_state.resp.exit_reason[EILC_EXIT_ENCLAVE_BIT] = i_in_enclave;
			end
			if (commit && i_req.op == EILC_OP_ID_QUERY && i_req.leaf == EILC_ID_LEAF
				&& i_req.subleaf == EILC_ID_SUBLEAF)
			begin
				next_state.resp.id_data[EILC_ID_GEN1_BIT]      = 1'b1;
				next_state.resp.id_data[EILC_ID_GEN2_BIT]      = i_gen2;
				next_state.resp.id_data[EILC_ID_OVERSUB_BIT_A] = 1'b1;
				next_state.resp.id_data[EILC_ID_OVERSUB_BIT_B] = 1'b1;
			end
			if (commit && i_req.op == EILC_OP_PAGE_INFO_READ)
			begin
				next_state.resp.page_type = map_entry.page_type;
				next_state.resp.owner     = map_entry.owner;
				next_state.info_ctx       = map_ctx;
				next_state.vchild_locked  = map_vchild;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign o_resp          = state.resp;
	assign o_info_ctx      = state.info_ctx;
	assign o_vchild_locked = state.vchild_locked;

endmodule

// File: tb/eilc_chk.sv
// Port checks for the enclave legality block
`timescale 1ns/1ps
module eilc_chk
	import eilc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire eilc_req_s  i_req,
	input  wire eilc_ctrl_s i_ctrl,
	input  wire logic       i_in_enclave,
	input  wire logic       i_gen2,
	input  wire eilc_resp_s o_resp
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Request taken inside an enclave
	logic        in_req;
	logic [31:0] spin_code;
	assign in_req    = i_req.valid && i_in_enclave;
	assign spin_code = 32'(EILC_EXIT_SPIN_WAIT) | (32'h1 << EILC_EXIT_ENCLAVE_BIT);

	// Verdict one cycle after a request
	property p_res(logic cond, eilc_res_e r);
		cond |=> o_resp.valid && o_resp.result == r;
	endproperty

	////////////////////////////////////////////////////////////////////////////
	ud_query_a: assert property (p_res(in_req && i_req.op inside
		{[EILC_OP_ID_QUERY:EILC_OP_VM_FUNCTION]}, EILC_RES_INVALID_OPCODE))
		else $error("query class did not fault");
	ud_port_a: assert property (p_res(in_req && i_req.op inside
		{[EILC_OP_PORT_IN:EILC_OP_STRING_PORT_OUT]}, EILC_RES_INVALID_OPCODE))
		else $error("port class did not fault");
	ud_segment_a: assert property (p_res(in_req && i_req.op inside
		{[EILC_OP_FAR_CALL:EILC_OP_FAST_SYS_ENTRY]}, EILC_RES_INVALID_OPCODE))
		else $error("segment class did not fault");
	ud_status_a: assert property (p_res(in_req && i_req.op == EILC_OP_MSW_STORE,
		EILC_RES_INVALID_OPCODE)) else $error("status store did not fault");
	nested_entry_a: assert property (p_res(in_req && i_req.op inside
		{EILC_OP_ENTRY_LEAF, EILC_OP_RESUME_LEAF}, EILC_RES_GEN_PROT))
		else $error("nested entry not refused");
	ts_gen1_a: assert property (in_req && !i_gen2 && i_req.op inside
		{EILC_OP_TIMESTAMP, EILC_OP_TIMESTAMP_ID} |=> o_resp.result == EILC_RES_INVALID_OPCODE)
		else $error("timestamp legal on first generation");
	ts_exit_a: assert property (in_req && i_gen2 && i_ctrl.timestamp_exit
		&& !i_ctrl.timestamp_disable && i_req.op == EILC_OP_TIMESTAMP_ID
		|=> o_resp.result == EILC_RES_VM_EXIT ##0 o_resp.exit_reason[15:0] == EILC_EXIT_TIMESTAMP)
		else $error("timestamp exit missing");
	rand_exit_a: assert property (in_req && i_req.op inside
		{EILC_OP_RANDOM, EILC_OP_RANDOM_SEED} |=> o_resp.result ==
		($past(i_ctrl.random_exit) ? EILC_RES_VM_EXIT : EILC_RES_LEGAL))
		else $error("random op verdict wrong");
	exit_flag_a: assert property (o_resp.valid && o_resp.result == EILC_RES_VM_EXIT
		|-> o_resp.exit_reason[EILC_EXIT_ENCLAVE_BIT] == $past(i_in_enclave))
		else $error("enclave exit flag wrong");
	spin_exit_a: assert property (in_req && i_req.op == EILC_OP_SPIN_WAIT
		&& i_ctrl.spin_wait_exit |=> o_resp.exit_reason == spin_code)
		else $error("spin exit reason wrong");
	spin_loop_a: assert property (p_res(in_req && i_req.op == EILC_OP_SPIN_WAIT
		&& !i_ctrl.spin_wait_exit, EILC_RES_LEGAL)) else $error("spin loop exit taken");
	trap_legal_a: assert property (p_res(in_req && i_req.op inside
		{EILC_OP_SINGLE_STEP, EILC_OP_BREAKPOINT}, EILC_RES_LEGAL))
		else $error("trap op not legal");
	fault_commit_a: assert property (o_resp.valid && o_resp.result != EILC_RES_LEGAL
		|-> !o_resp.commit) else $error("faulting op committed");

	// Main scenarios reached
	cover property (o_resp.valid && o_resp.result == EILC_RES_VM_EXIT);
	cover property (o_resp.valid && o_resp.result == EILC_RES_PAGE_FAULT);
	cover property (o_resp.valid && o_resp.result == EILC_RES_GEN_PROT);
endmodule

bind eilc_top eilc_chk i_eilc_chk (
	.i_clk        (i_clk),
	.i_rst        (i_rst),
	.i_req        (i_req),
	.i_ctrl       (i_ctrl),
	.i_in_enclave (i_in_enclave),
	.i_gen2       (i_gen2),
	.o_resp       (o_resp)
);

// File: tb/eilc_mon.sv
// Monitor model: arms exit controls, clears them after an exit
`timescale 1ns/1ps
module eilc_mon
	import eilc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_arm,
	input  wire eilc_resp_s i_resp,
	output logic            o_rand_exit,
	output logic            o_spin_exit
);
	// Clear both controls on an exit so the guest re-executes
	always_ff @(posedge i_clk)
	begin
		if (i_rst || (i_resp.valid && i_resp.result == EILC_RES_VM_EXIT))
		begin
			o_rand_exit <= 1'b0;
			o_spin_exit <= 1'b0;
		end
		else if (i_arm)
		begin
			o_rand_exit <= 1'b1;
			o_spin_exit <= 1'b1;
		end
	end
endmodule

// File: tb/tb_eilc_top.sv
// Self-checking bench for the enclave legality block
`timescale 1ns/1ps
module tb_eilc_top
	import eilc_pkg::*;
;
	// Ordinary case row
	typedef struct packed {
		eilc_op_e  op;
		logic      gen2;
		logic      tsd;
		logic      tse;
		logic      lp;
		eilc_res_e res;
	} eilc_row_s;
	localparam eilc_row_s TBL [11] = '{
		'{EILC_OP_ENTRY_LEAF, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_GEN_PROT},
		'{EILC_OP_RESUME_LEAF, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_GEN_PROT},
		'{EILC_OP_TIMESTAMP, 1'b0, 1'b0, 1'b0, 1'b0, EILC_RES_INVALID_OPCODE},
		'{EILC_OP_TIMESTAMP_ID, 1'b0, 1'b0, 1'b0, 1'b0, EILC_RES_INVALID_OPCODE},
		'{EILC_OP_TIMESTAMP, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_LEGAL},
		'{EILC_OP_TIMESTAMP, 1'b1, 1'b1, 1'b0, 1'b0, EILC_RES_GEN_PROT},
		'{EILC_OP_TIMESTAMP_ID, 1'b1, 1'b0, 1'b1, 1'b0, EILC_RES_VM_EXIT},
		'{EILC_OP_RANDOM_SEED, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_LEGAL},
		'{EILC_OP_SPIN_WAIT, 1'b1, 1'b0, 1'b0, 1'b1, EILC_RES_LEGAL},
		'{EILC_OP_SINGLE_STEP, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_LEGAL},
		'{EILC_OP_BREAKPOINT, 1'b1, 1'b0, 1'b0, 1'b0, EILC_RES_LEGAL}
	};
	localparam logic [63:0] EBIT = 64'h1 << EILC_EXIT_ENCLAVE_BIT;

	logic            i_clk = 1'b0;
	logic            i_rst;
	eilc_req_s       req;
	eilc_ctrl_s      tbc;
	eilc_ctrl_s      ctrl;
	logic            enc;
	logic            gen2;
	logic            map_load;
	logic [3:0]      map_page;
	eilc_map_entry_s map_entry;
	logic            flush;
	logic            arm;
	logic            m_rand;
	logic            m_spin;
	eilc_resp_s      o_resp;
	logic [63:0]     o_info_ctx;
	logic            o_vchild_locked;
	int              errors = 0;
	int              check_count = 0;
	int              cycles = 0;

	////////////////////////////////////////////////////////////////////////////
	// Clock and monitor-owned exit controls
	always #2 i_clk = ~i_clk;
	assign ctrl = '{tbc.timestamp_exit, m_rand, m_spin, tbc.spin_loop_exit,
		tbc.timestamp_disable, tbc.current_privilege_level};

	eilc_top i_eilc_top (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_ctrl(ctrl),
		.i_in_enclave(enc), .i_gen2(gen2), .i_map_load(map_load), .i_map_page(map_page),
		.i_map_entry(map_entry), .i_tlb_flush(flush), .o_resp(o_resp),
		.o_info_ctx(o_info_ctx), .o_vchild_locked(o_vchild_locked));
	eilc_mon i_eilc_mon (.i_clk(i_clk), .i_rst(i_rst), .i_arm(arm), .i_resp(o_resp),
		.o_rand_exit(m_rand), .o_spin_exit(m_spin));

	////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One request, verdict read a cycle later
	task automatic do_op(input eilc_op_e op, input logic [3:0] pg, input logic [2:0] pm,
		input eilc_res_e exp);
		req.valid = 1'b1;
		req.op = op;
		req.page = pg;
		req.perm = pm;
		@(negedge i_clk);
		chk("valid", 64'(o_resp.valid), 64'h1);
		chk("result", 64'(o_resp.result), 64'(exp));
		chk("commit", 64'(o_resp.commit), 64'(exp == EILC_RES_LEGAL));
	endtask

	// Page map write
	task automatic load(input logic [3:0] pg, input logic vld, input logic [7:0] ty);
		map_load = 1'b1;
		map_page = pg;
		map_entry = '{vld, 3'h1, ty, 4'h0};
		@(negedge i_clk);
		map_load = 1'b0;
	endtask

	// Counts and verdict
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Cycle ceiling against a hung run
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			errors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		i_rst = 1'b1;
		req = '0;
		tbc = '0;
		tbc.current_privilege_level = 2'h3;
		enc = 1'b1;
		gen2 = 1'b0;
		map_load = 1'b0;
		map_page = 4'h0;
		map_entry = '0;
		flush = 1'b0;
		arm = 1'b0;
		repeat (20) @(negedge i_clk);
		chk("rst", 64'(o_resp.valid), 64'h0);
		i_rst = 1'b0;
		foreach (TBL[k])
		begin
			gen2 = TBL[k].gen2;
			tbc.timestamp_disable = TBL[k].tsd;
			tbc.timestamp_exit = TBL[k].tse;
			tbc.spin_loop_exit = TBL[k].lp;
			do_op(TBL[k].op, 4'h0, 3'h0, TBL[k].res);
		end
		tbc = '0;
		tbc.current_privilege_level = 2'h3;
		for (int k = int'(EILC_OP_ID_QUERY); k <= int'(EILC_OP_MSW_STORE); k++)
			do_op(eilc_op_e'(k), 4'h0, 3'h0, EILC_RES_INVALID_OPCODE);
		// Exit then re-execute after the monitor clears its control
		req.valid = 1'b0;
		arm = 1'b1;
		@(negedge i_clk);
		arm = 1'b0;
		do_op(EILC_OP_RANDOM, 4'h0, 3'h0, EILC_RES_VM_EXIT);
		chk("reason", 64'(o_resp.exit_reason), EBIT | 64'(EILC_EXIT_RANDOM));
		req.valid = 1'b0;
		@(negedge i_clk);
		do_op(EILC_OP_RANDOM, 4'h0, 3'h0, EILC_RES_LEGAL);
		do_op(EILC_OP_SPIN_WAIT, 4'h0, 3'h0, EILC_RES_LEGAL);
		// Exit outside an enclave leaves the flag clear
		enc = 1'b0;
		tbc.spin_loop_exit = 1'b1;
		tbc.current_privilege_level = 2'h0;
		do_op(EILC_OP_SPIN_WAIT, 4'h0, 3'h0, EILC_RES_VM_EXIT);
		chk("reason", 64'(o_resp.exit_reason), 64'(EILC_EXIT_SPIN_WAIT));
		tbc.spin_loop_exit = 1'b0;
		tbc.current_privilege_level = 2'h3;
		req.leaf = EILC_ID_LEAF;
		req.subleaf = EILC_ID_SUBLEAF;
		do_op(EILC_OP_ID_QUERY, 4'h0, 3'h0, EILC_RES_LEGAL);
		chk("oversub", 64'(o_resp.id_data[EILC_ID_OVERSUB_BIT_B -: 2]), 64'h3);
		// Permission extension against cached translations
		req.valid = 1'b0;
		enc = 1'b1;
		load(4'h0, 1'b1, EILC_TYPE_CONTROL);
		load(4'h1, 1'b1, 8'h01);
		load(4'h3, 1'b0, 8'h01);
		do_op(EILC_OP_ACCESS, 4'h1, 3'h1, EILC_RES_LEGAL);
		do_op(EILC_OP_PERM_EXTEND, 4'h1, 3'h3, EILC_RES_LEGAL);
		do_op(EILC_OP_ACCESS, 4'h1, 3'h3, EILC_RES_PAGE_FAULT);
		do_op(EILC_OP_ACCESS, 4'h1, 3'h3, EILC_RES_LEGAL);
		do_op(EILC_OP_PERM_EXTEND, 4'h1, 3'h7, EILC_RES_LEGAL);
		req.valid = 1'b0;
		flush = 1'b1;
		@(negedge i_clk);
		flush = 1'b0;
		do_op(EILC_OP_ACCESS, 4'h1, 3'h7, EILC_RES_LEGAL);
		req.op = EILC_OP_PERM_EXTEND;
		req.page = 4'h3;
		req.valid = 1'b1;
		@(negedge i_clk);
		do_op(EILC_OP_ACCESS, 4'h3, 3'h3, EILC_RES_PAGE_FAULT);
		// Control structure context, marker and page info
		req.ctx = 64'h0123_4567_89ab_cdef;
		do_op(EILC_OP_CONTEXT_SET, 4'h0, 3'h0, EILC_RES_LEGAL);
		do_op(EILC_OP_VCHILD_MARK, 4'h0, 3'h0, EILC_RES_LEGAL);
		do_op(EILC_OP_PAGE_INFO_READ, 4'h1, 3'h0, EILC_RES_LEGAL);
		chk("type", 64'(o_resp.page_type), 64'h1);
		chk("owner", 64'(o_resp.owner), 64'h0);
		chk("ctx", o_info_ctx, 64'h0123_4567_89ab_cdef);
		chk("lock", 64'(o_vchild_locked), 64'h1);
		summarize();
	end
endmodule
